// ==== acc_regs.vh ====
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

`define ACC_IDX_MODE     3'h0
`define ACC_IDX_STAT     3'h1
`define ACC_IDX_P_OFF    3'h2
`define ACC_IDX_A_GAIN   3'h5
`define ACC_IDX_P_DATA   3'h6
`define ACC_IDX_A_DATA   3'h7

`define ACC_MODE_RST     8'h00
`define ACC_MODE_PDOWN   3'h0
`define ACC_MODE_IDLE    3'h1
`define ACC_MODE_CONT    3'h2
`define ACC_MODE_SINGLE  3'h3
`define ACC_MODE_CAL_BIT 2
`define ACC_MODE_SYS_BIT 1
`define ACC_MODE_FS_BIT  0
`define ACC_MODE_EN_P    4

`define ACC_ST_ERR_LSB   2
`define ACC_ST_NOREF     4
`define ACC_ST_BUSY_LSB  5

`define ACC_OFF_RST      24'h000000
`define ACC_GAIN_RST     24'h800000
`define ACC_GAIN_FRAC    23
`define ACC_REF_LOST     24'hFFFFFF

`define ACC_CAL_SETTLE   2'h2
`define ACC_LOAD_WORDS   3'h4

`define ACC_ROUTE_PINS   2'h0
`define ACC_ROUTE_ZERO   2'h1
`define ACC_ROUTE_FULL   2'h2

`define ACC_RESP_OKAY    2'h0
`define ACC_RESP_SLVERR  2'h2

`endif

// ==== acc_coef_mem.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"

// Word 0/1: primary offset/gain, word 2/3: auxiliary offset/gain
module acc_coef_mem (
  input  wire        sys_clk,
  input  wire        rst_sync_b,
  input  wire        we,
  input  wire [1:0]  waddr,
  input  wire [23:0] wdata,
  input  wire [1:0]  raddr,
  output reg  [23:0] rdata,
  output wire [95:0] all_words
);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_word
      reg [23:0] word_reg;
      always @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          word_reg <= (gi % 2 == 1) ? `ACC_GAIN_RST : `ACC_OFF_RST;
        end else if (we && waddr == gi) begin
          word_reg <= wdata;
        end
      end
      assign all_words[24*gi +: 24] = word_reg;
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata <= 24'h000000;
    end else begin
      rdata <= all_words[24*raddr +: 24];
    end
  end
endmodule

// ==== acc_corrector.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"

// Gain is unsigned with 23 fraction bits, so 800000h is unity
module acc_corrector (
  input  wire        sys_clk,
  input  wire        rst_sync_b,
  input  wire        in_valid,
  input  wire [23:0] in_data,
  input  wire [23:0] offset,
  input  wire [23:0] gain,
  output reg         out_valid,
  output reg  [23:0] out_data
);
  wire signed [24:0] diff;
  wire signed [49:0] prod;
  wire        [26:0] scaled;

  // Subtract first, then scale
  assign diff   = $signed({in_data[23], in_data}) - $signed({offset[23], offset});
  assign prod   = diff * $signed({1'b0, gain});
  assign scaled = prod[`ACC_GAIN_FRAC+26:`ACC_GAIN_FRAC];

  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_valid <= 1'b0;
      out_data  <= 24'h000000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        // Clip instead of wrapping when gain pushes past full scale
        if (scaled[26:23] == 4'h0 || scaled[26:23] == 4'hF) begin
          out_data <= scaled[23:0];
        end else begin
          out_data <= scaled[26] ? 24'h800000 : 24'h7FFFFF;
        end
      end
    end
  end
endmodule

// ==== acc_cal_ctrl.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"

module acc_cal_ctrl (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [1:0]  nv_addr,
  input  wire [23:0] nv_data,
  input  wire [47:0] filt_data,
  input  wire [1:0]  filt_valid,
  input  wire        missing_reference_flag,
  output wire [3:0]  cal_route,
  output wire [1:0]  force_slowest_rate,
  output wire [1:0]  conv_enable,
  output wire [47:0] result_data,
  output wire [1:0]  result_valid
);
  localparam ST_LOAD = 1'b0;
  localparam ST_RUN  = 1'b1;

  // Bit 3 flags a mapped address, bits 2:0 give the word index
  function [3:0] acc_decode;
    input [7:0] addr;
    begin
      acc_decode = {(addr[7:5] == 3'h0) && (addr[1:0] == 2'h0), addr[4:2]};
    end
  endfunction

  function [31:0] acc_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      acc_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          acc_merge[8*k +: 8] = new_val[8*k +: 8];
        end
      end
    end
  endfunction

  reg        rst_meta_b;
  reg        rst_sync_b;
  reg        state_reg;
  reg [2:0]  load_cnt_reg;
  reg [7:0]  mode_reg;
  reg        cal_run_reg;
  reg [1:0]  done_flag_reg;
  reg [1:0]  err_flag_reg;
  reg        aw_held_reg;
  reg [7:0]  awaddr_reg;
  reg        w_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg [31:0] rd_reg;
  reg        rmem_reg;
  reg [1:0]  rcidx_reg;

  reg        mem_we;
  reg [1:0]  mem_waddr;
  reg [23:0] mem_wdata;

  wire [95:0] coef_all;
  wire [23:0] mem_rd;
  wire [1:0]  busy_vec;
  wire [1:0]  pend_vec;
  wire [1:0]  full_vec;
  wire [47:0] res_vec;
  wire [1:0]  grant_vec;
  wire [1:0]  done_set;
  wire [1:0]  err_set;
  wire [1:0]  conv_on;

  wire        running = (state_reg == ST_RUN);
  wire [3:0]  wr_dec  = acc_decode(awaddr_reg);
  wire [3:0]  rd_dec  = acc_decode(s_axi_araddr);
  wire [2:0]  wr_cidx = wr_dec[2:0] - `ACC_IDX_P_OFF;
  wire [2:0]  rd_cidx = rd_dec[2:0] - `ACC_IDX_P_OFF;
  wire        wr_coef = wr_dec[3] && wr_dec[2:0] >= `ACC_IDX_P_OFF && wr_dec[2:0] <= `ACC_IDX_A_GAIN;
  wire        rd_coef = rd_dec[3] && rd_dec[2:0] >= `ACC_IDX_P_OFF && rd_dec[2:0] <= `ACC_IDX_A_GAIN;
  // Bus writes yield to coefficient loading and calibration results
  wire        wr_go   = aw_held_reg & w_held_reg & ~s_axi_bvalid & running & ~(|pend_vec);
  wire        ar_go   = s_axi_arvalid & ~s_axi_rvalid;
  wire        mode_wr_go = wr_go & wr_dec[3] & (wr_dec[2:0] == `ACC_IDX_MODE) & wstrb_reg[0];
  wire [3:0]  stat_clr = (wr_go & wr_dec[3] & (wr_dec[2:0] == `ACC_IDX_STAT) & wstrb_reg[0]) ?
                         wdata_reg[3:0] : 4'h0;
  wire [31:0] coef_merged = acc_merge({8'h00, coef_all[24*wr_cidx[1:0] +: 24]}, wdata_reg, wstrb_reg);
  wire        cal_finish = cal_run_reg & ~(|busy_vec) & ~(|pend_vec);
  wire [2:0]  mode_fld = mode_reg[2:0];

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_rdata   = rmem_reg ? {8'h00, mem_rd} : rd_reg;
  assign nv_addr       = load_cnt_reg[1:0];

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Power-on copy; storage answers one cycle after the address
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg    <= ST_LOAD;
      load_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          load_cnt_reg <= load_cnt_reg + 3'h1;
          if (load_cnt_reg == `ACC_LOAD_WORDS) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          load_cnt_reg <= 3'h0;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  always @* begin
    mem_we    = 1'b0;
    mem_waddr = 2'h0;
    mem_wdata = 24'h000000;
    if (!running && load_cnt_reg != 3'h0) begin
      mem_we    = 1'b1;
      mem_waddr = load_cnt_reg[1:0] - 2'h1;
      mem_wdata = nv_data;
    end else if (grant_vec[0]) begin
      mem_we    = 1'b1;
      mem_waddr = {1'b0, full_vec[0]};
      mem_wdata = res_vec[23:0];
    end else if (grant_vec[1]) begin
      mem_we    = 1'b1;
      mem_waddr = {1'b1, full_vec[1]};
      mem_wdata = res_vec[47:24];
    end else if (wr_go && wr_coef) begin
      mem_we    = 1'b1;
      mem_waddr = wr_cidx[1:0];
      mem_wdata = coef_merged[23:0];
    end
  end

  acc_coef_mem u_mem (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .we         (mem_we),
    .waddr      (mem_waddr),
    .wdata      (mem_wdata),
    .raddr      (ar_go ? rd_cidx[1:0] : rcidx_reg),
    .rdata      (mem_rd),
    .all_words  (coef_all)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_conv
      reg        busy_reg;
      reg [1:0]  settle_reg;
      reg        nref_seen_reg;
      reg        full_reg;
      reg        sys_reg;
      reg        pend_reg;
      reg [23:0] res_reg;
      reg [23:0] data_reg;
      reg        dvalid_reg;
      wire [23:0] corr;
      wire        corr_valid;
      wire        nref_now  = nref_seen_reg | missing_reference_flag;
      // Chopping needs two words before the result has settled
      wire        last_word = busy_reg & filt_valid[gi] & (settle_reg == `ACC_CAL_SETTLE - 2'h1);
      wire        start = mode_wr_go & wdata_reg[`ACC_MODE_CAL_BIT] & wdata_reg[`ACC_MODE_EN_P + gi];
      wire        take  = corr_valid & conv_on[gi];

      acc_corrector u_corr (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .in_valid   (filt_valid[gi] & ~busy_reg),
        .in_data    (filt_data[24*gi +: 24]),
        .offset     (coef_all[48*gi +: 24]),
        .gain       (coef_all[48*gi+24 +: 24]),
        .out_valid  (corr_valid),
        .out_data   (corr)
      );

      always @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          busy_reg      <= 1'b0;
          settle_reg    <= 2'h0;
          nref_seen_reg <= 1'b0;
          full_reg      <= 1'b0;
          sys_reg       <= 1'b0;
          pend_reg      <= 1'b0;
          res_reg       <= 24'h000000;
          data_reg      <= 24'h000000;
          dvalid_reg    <= 1'b0;
        end else begin
          if (start) begin
            busy_reg      <= 1'b1;
            settle_reg    <= 2'h0;
            nref_seen_reg <= missing_reference_flag;
            full_reg      <= wdata_reg[`ACC_MODE_FS_BIT];
            sys_reg       <= wdata_reg[`ACC_MODE_SYS_BIT];
          end else if (busy_reg) begin
            nref_seen_reg <= nref_now;
            if (filt_valid[gi]) begin
              settle_reg <= settle_reg + 2'h1;
            end
            if (last_word) begin
              busy_reg <= 1'b0;
              if (!nref_now) begin
                pend_reg <= 1'b1;
                res_reg  <= filt_data[24*gi +: 24];
              end
            end
          end
          if (grant_vec[gi]) begin
            pend_reg <= 1'b0;
          end
          dvalid_reg <= take;
          if (take) begin
            // A lost reference forces an all-ones result
            data_reg <= missing_reference_flag ? `ACC_REF_LOST : corr;
          end
        end
      end

      assign busy_vec[gi]  = busy_reg;
      assign pend_vec[gi]  = pend_reg;
      assign full_vec[gi]  = full_reg;
      assign res_vec[24*gi +: 24] = res_reg;
      assign grant_vec[gi] = running & pend_reg & ((gi == 0) || !pend_vec[0]);
      assign err_set[gi]   = last_word & nref_now;
      assign done_set[gi]  = err_set[gi] | grant_vec[gi] | dvalid_reg;
      assign cal_route[2*gi +: 2] = (busy_reg & ~sys_reg) ?
                                    (full_reg ? `ACC_ROUTE_FULL : `ACC_ROUTE_ZERO) : `ACC_ROUTE_PINS;
      assign force_slowest_rate[gi] = busy_reg;
      assign conv_on[gi]   = mode_reg[`ACC_MODE_EN_P + gi] & ~busy_reg &
                             (mode_fld == `ACC_MODE_CONT || mode_fld == `ACC_MODE_SINGLE);
      assign conv_enable[gi] = mode_reg[`ACC_MODE_EN_P + gi] & (mode_fld != `ACC_MODE_PDOWN);
      assign result_data[24*gi +: 24] = data_reg;
      assign result_valid[gi] = dvalid_reg;
    end
  endgenerate

  // Mode field and sticky flags; a set in the clearing cycle wins
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode_reg      <= `ACC_MODE_RST;
      cal_run_reg   <= 1'b0;
      done_flag_reg <= 2'h0;
      err_flag_reg  <= 2'h0;
    end else begin
      if (mode_wr_go) begin
        mode_reg    <= wdata_reg[7:0];
        cal_run_reg <= wdata_reg[`ACC_MODE_CAL_BIT];
      end else if (cal_finish) begin
        mode_reg[2:0] <= `ACC_MODE_IDLE;
        cal_run_reg   <= 1'b0;
      end else if (mode_fld == `ACC_MODE_SINGLE && (|result_valid)) begin
        mode_reg[2:0] <= `ACC_MODE_IDLE;
      end
      done_flag_reg <= (done_flag_reg & ~stat_clr[1:0]) | done_set;
      err_flag_reg  <= (err_flag_reg & ~stat_clr[3:2]) | err_set;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held_reg  <= 1'b0;
      awaddr_reg   <= 8'h00;
      w_held_reg   <= 1'b0;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_dec[3] ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `ACC_RESP_OKAY;
      rd_reg       <= 32'h00000000;
      rmem_reg     <= 1'b0;
      rcidx_reg    <= 2'h0;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_dec[3] ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      rmem_reg     <= rd_coef;
      rcidx_reg    <= rd_cidx[1:0];
      rd_reg       <= 32'h00000000;
      if (rd_dec[3]) begin
        case (rd_dec[2:0])
          `ACC_IDX_MODE:   rd_reg <= {24'h000000, mode_reg};
          `ACC_IDX_STAT:   rd_reg <= {25'h0000000, busy_vec, missing_reference_flag, err_flag_reg, done_flag_reg};
          `ACC_IDX_P_DATA: rd_reg <= {8'h00, result_data[23:0]};
          `ACC_IDX_A_DATA: rd_reg <= {8'h00, result_data[47:24]};
          default:         rd_reg <= 32'h00000000;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== acc_cal_ctrl_asserts.sv ====
`timescale 1ns/1ps
module acc_cal_chk (
  input wire        sys_clk,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  filt_valid,
  input wire        missing_reference_flag,
  input wire [3:0]  cal_route,
  input wire [1:0]  force_slowest_rate,
  input wire [47:0] result_data,
  input wire [1:0]  result_valid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved early");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer moved early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:16] s_axi_bvalid) else $error("write answer missing");
  route_slow_a: assert property ((cal_route[1:0] == 2'h0 || force_slowest_rate[0]) &&
    (cal_route[3:2] == 2'h0 || force_slowest_rate[1])) else $error("internal source without slow rate");
  res_lat_a: assert property ((result_valid & ~$past(filt_valid, 2)) == 2'h0)
    else $error("result without filter word");
  cal_quiet_a: assert property (force_slowest_rate[0] && $past(force_slowest_rate[0], 2) |-> !result_valid[0])
    else $error("result during calibration");
  noref_ones_a: assert property (result_valid[0] && missing_reference_flag && $past(missing_reference_flag) &&
    $past(missing_reference_flag, 2) |-> result_data[23:0] == 24'hFFFFFF) else $error("result not all ones");
endmodule

bind acc_cal_ctrl acc_cal_chk chk (.*);

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e_v, g_v) \
  begin \
    samples_checked++; \
    if ((g_v) !== (e_v)) begin \
      err_count++; \
      $display("Error %s expected %h seen %h", nm, e_v, g_v); \
    end \
  end
module testbench;
  logic        sys_clk, rst_b, missing_reference_flag;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, cal_route;
  logic [1:0]  s_axi_bresp, s_axi_rresp, nv_addr, filt_valid, force_slowest_rate, conv_enable, result_valid, rs;
  logic [23:0] nv_data;
  logic [47:0] filt_data, result_data;
  int          err_count, samples_checked, bus_lag;

  acc_cal_ctrl DUT (.*);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Factory store answers one cycle after the address, as the loader expects
  always @(posedge sys_clk) nv_data <= 24'h5A5A50 + {22'h0, nv_addr};

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Ready rises after the first edge, bus_lag edges later when set, so the slave must hold its answer
      do begin
        @(posedge sys_clk);
        n++;
        if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (n > bus_lag && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 100);
      if (n >= 100) err_count++;
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    begin
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge sys_clk);
        n++;
        if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (n > bus_lag && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 100);
      if (n >= 100) err_count++;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    begin
      axi_read(a);
      `CHK("read data", e, rd)
    end
  endtask

  task automatic feed(input int ch, input logic [23:0] w);
    begin
      filt_data[ch*24 +: 24] <= w;
      filt_valid[ch] <= 1'b1;
      @(posedge sys_clk);
      filt_valid[ch] <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
  endtask

  task automatic do_cal(input int ch, input logic [2:0] code, input logic lost);
    logic [1:0] route;
    begin
      route = (code == 3'h4) ? 2'h1 : (code == 3'h5) ? 2'h2 : 2'h0;
      axi_write(8'h04, 32'hF);
      missing_reference_flag <= lost;
      filt_data[ch*24 +: 24] <= 24'h0C0000 + {21'h0, code};
      axi_write(8'h00, {26'h0, ch == 1, ch == 0, 1'b0, code});
      @(posedge sys_clk);
      `CHK("slow rate", 1'b1, force_slowest_rate[ch])
      `CHK("route", route, cal_route[ch*2 +: 2])
      // First word is settling only; the second is the calibration point
      feed(ch, 24'h3FFFFF);
      feed(ch, 24'h0C0000 + code);
      missing_reference_flag <= 1'b0;
      `CHK("slow rate end", 1'b0, force_slowest_rate[ch])
      rd_chk(8'h00, ch ? 32'h21 : 32'h11);
      rd_chk(8'h04, (lost ? 32'h5 : 32'h1) << ch);
    end
  endtask

  task automatic t_load;
    begin
      for (int k = 0; k < 4; k++) rd_chk(8'h08 + 8'(k * 4), 32'h5A5A50 + k);
      // Late ready makes the slave hold its answers
      bus_lag = 3;
      rd_chk(8'h0C, 32'h5A5A51);
      axi_read(8'h20);
      `CHK("unmapped read resp", 2'h2, rs)
      axi_write(8'h22, 32'h1);
      `CHK("unmapped write resp", 2'h2, rs)
      bus_lag = 0;
      $display("test load done");
    end
  endtask

  task automatic t_cal_codes;
    logic [2:0] code;
    int ch;
    begin
      for (int i = 4; i < 8; i++) begin
        code = i[2:0];
        ch = code[1];
        do_cal(ch, code, 1'b0);
        rd_chk(8'h08 + 8'(ch * 8) + {5'h0, code[0], 2'h0}, 32'h0C0000 + code);
        if (code == 3'h7) rd_chk(8'h0C, 32'h0C0005);
      end
      $display("test cal_codes done");
    end
  endtask

  task automatic t_noref;
    begin
      axi_write(8'h0C, 32'h123456);
      axi_write(8'h10, 32'h654321);
      do_cal(0, 3'h5, 1'b1);
      do_cal(1, 3'h4, 1'b1);
      rd_chk(8'h0C, 32'h123456);
      rd_chk(8'h10, 32'h654321);
      $display("test noref done");
    end
  endtask

  task automatic feed_res(input logic [23:0] x, input logic [23:0] e);
    int n;
    begin
      n = 0;
      filt_data[23:0] <= x;
      filt_valid[0] <= 1'b1;
      @(posedge sys_clk);
      filt_valid[0] <= 1'b0;
      while (result_valid[0] !== 1'b1 && n < 10) begin
        @(posedge sys_clk);
        n++;
      end
      `CHK("result valid", 1'b1, result_valid[0])
      `CHK("corrected", e, result_data[23:0])
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic t_correct;
    begin
      axi_write(8'h08, 32'h100);
      axi_write(8'h0C, 32'h400000);
      axi_write(8'h00, 32'h13);
      `CHK("conv enable", 2'h1, conv_enable)
      feed_res(24'h001100, 24'h000800);
      rd_chk(8'h00, 32'h11);
      rd_chk(8'h18, 32'h000800);
      axi_write(8'h00, 32'h12);
      feed_res(24'h000500, 24'h000200);
      rd_chk(8'h00, 32'h12);
      axi_write(8'h00, 32'h10);
      `CHK("conv enable off", 2'h0, conv_enable)
      missing_reference_flag <= 1'b1;
      axi_write(8'h00, 32'h13);
      feed_res(24'h001100, 24'hFFFFFF);
      missing_reference_flag <= 1'b0;
      $display("test correct done");
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    $display("Error watchdog expected done seen hang");
    report_and_stop;
  end

  initial begin
    err_count = 0;
    samples_checked = 0;
    bus_lag = 0;
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, missing_reference_flag} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, filt_data, filt_valid} = '0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge sys_clk);
    t_load;
    t_cal_codes;
    t_noref;
    t_correct;
    report_and_stop;
  end
endmodule
